// ### sel_dev.sv
/*
 device end: serial command front end with signature read, deep power-down,
 hold, write-protect gating and write-cycle start.
 assumes the master clocks far below i_sys_clk (at least 8 cycles per half
 period) and that i_wip comes from the programming engine on this clock.
*/
// What this block does
// - deep power-down ignores all but signature command
// - signature works awake, refused while writing
// - command, 24 dummy bits, then 8-bit signature
// - chip select high ends it, standby follows
// - extra clocks keep repeating the signature
// - early deselect still releases, after release delay
// - low selects, high deselects into standby
// - running write finishes before standby
// - deselected means serial output released
// - deselect after valid write starts cycle
// - master selects once after power-up first
// - output changes after falling clock edge
// - input sampled on rising clock edge
// - pin low and enable bit refuse status
// - pin change after write start ignored
// - enable bit clear ignores the pin
// - master keeps pause high when unused
// - pause mid-sequence keeps state, stays selected
// - pause acts now or at next fall
// - paused ignores clock, input and output
// - resume only while clock is low
// - pause low releases output at once
// - power-down only if deselected after bit eight
`timescale 1ns/1ps
`include "sel_cfg.svh"
module sel_dev
    import sel_pkg::*;
#(
    parameter logic [7:0] SIGNATURE = `SEL_SIG_DEFAULT // arbitrary value
)(
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // link
    sel_link_if.dev         lnk,
    // device core
    input  wire logic       i_pin_enable,
    input  wire logic       i_wip,
    output logic            o_dpd,
    output logic            o_standby,
    output logic            o_wr_start,
    output logic            o_status_wr,
    output logic            o_status_refused,
    output logic [7:0]      o_status_data
);

    localparam sel_dev_st_t RST = '{
        cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
        hold_s1: 1'b1, hold_s2: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1,
        so_oe_n: 1'b1, standby: 1'b1, phase: PH_IDLE, default: '0};

    sel_dev_st_t s_ff;
    sel_dev_st_t nxt_s;
    logic        rise;
    logic        fall;
    logic        go;

    // the data write command counts whole data bytes after the address
    function automatic logic [5:0] cnt_inc(input logic [5:0] c, input logic wr);
        if (wr && c == `SEL_DATA_END)
            return `SEL_DATA_WRAP;
        else if (c == `SEL_CNT_MAX)
            return c;
        else
            return 6'(c + 6'd1);
    endfunction

    function automatic sel_ph_t cmd_phase(input logic [7:0] c, input logic dpd,
                                          input logic wip, input logic wel);
        if (dpd)
            return (c == `SEL_CMD_SIG) ? PH_ADDR : PH_SKIP;
        else if (c == `SEL_CMD_SIG)
            return wip ? PH_SKIP : PH_ADDR;
        else if ((c == `SEL_CMD_WRSR || c == `SEL_CMD_WRITE) && wel && !wip)
            return PH_DATA;
        else
            return PH_SKIP;
    endfunction

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.cs_s1 = lnk.cs_n;
        nxt_s.cs_s2 = s_ff.cs_s1;
        nxt_s.cs_d = s_ff.cs_s2;
        nxt_s.sck_s1 = lnk.sck;
        nxt_s.sck_s2 = s_ff.sck_s1;
        nxt_s.sck_d = s_ff.sck_s2;
        nxt_s.si_s1 = lnk.si;
        nxt_s.si_s2 = s_ff.si_s1;
        nxt_s.hold_s1 = lnk.hold_n;
        nxt_s.hold_s2 = s_ff.hold_s1;
        nxt_s.wp_s1 = lnk.wp_n;
        nxt_s.wp_s2 = s_ff.wp_s1;
        nxt_s.wr_start = 1'b0;
        nxt_s.st_wr = 1'b0;
        nxt_s.st_ref = 1'b0;
        rise = s_ff.sck_s2 && !s_ff.sck_d;
        fall = !s_ff.sck_s2 && s_ff.sck_d;

        // release delay runs out, then standby is allowed
        if (s_ff.rel_cnt != '0)
        begin
            nxt_s.rel_cnt = 8'(s_ff.rel_cnt - 8'd1);
            if (s_ff.rel_cnt == 8'd1)
                nxt_s.dpd = 1'b0;
        end

        // pause with clock high waits for the next fall
        if (!s_ff.hold_s2 && (!s_ff.sck_s2 || fall))
            nxt_s.paused = 1'b1;
        else if (s_ff.hold_s2 && !s_ff.sck_s2)
            nxt_s.paused = 1'b0;
        if (s_ff.cs_s2)
            nxt_s.paused = 1'b0;
        go = !s_ff.cs_s2 && !nxt_s.paused;

        if (!s_ff.cs_s2 && s_ff.cs_d)
        begin
            // first selection after reset only arms the front end
            nxt_s.phase = s_ff.armed ? PH_CMD : PH_SKIP;
            nxt_s.armed = 1'b1;
            nxt_s.cnt = '0;
            nxt_s.cmd = '0;
        end
        else if (s_ff.cs_s2 && !s_ff.cs_d)
        begin
            nxt_s.phase = PH_IDLE;
            if (s_ff.cmd == `SEL_CMD_DPD && s_ff.cnt == `SEL_CMD_BITS && !s_ff.dpd)
                nxt_s.dpd = 1'b1;
            if (s_ff.cmd == `SEL_CMD_WREN && s_ff.cnt == `SEL_CMD_BITS && !s_ff.dpd)
                nxt_s.wel = 1'b1;
            if (s_ff.phase == PH_DATA && s_ff.cmd == `SEL_CMD_WRSR && s_ff.cnt == `SEL_WRSR_END)
            begin
                if (s_ff.st_prot)
                    nxt_s.st_ref = 1'b1;
                else
                begin
                    nxt_s.st_wr = 1'b1;
                    nxt_s.wr_start = 1'b1;
                    nxt_s.wel = 1'b0;
                end
            end
            else if (s_ff.phase == PH_DATA && s_ff.cmd == `SEL_CMD_WRITE && s_ff.cnt == `SEL_DATA_END)
            begin
                nxt_s.wr_start = 1'b1;
                nxt_s.wel = 1'b0;
            end
        end
        else if (go && rise)
        begin
            nxt_s.sh = {s_ff.sh[6:0], s_ff.si_s2};
            nxt_s.cnt = cnt_inc(s_ff.cnt, s_ff.cmd == `SEL_CMD_WRITE);
            case (s_ff.phase)
                PH_CMD:
                begin
                    if (nxt_s.cnt == `SEL_CMD_BITS)
                    begin
                        nxt_s.cmd = nxt_s.sh;
                        nxt_s.phase = cmd_phase(nxt_s.sh, s_ff.dpd, i_wip, s_ff.wel);
                        // wake-up starts at bit eight, deselect or not
                        if (s_ff.dpd && nxt_s.sh == `SEL_CMD_SIG)
                            nxt_s.rel_cnt = `SEL_REL_CYC;
                    end
                end
                PH_ADDR:
                begin
                    if (nxt_s.cnt == `SEL_ADDR_END)
                    begin
                        nxt_s.phase = PH_SIG;
                        nxt_s.sig_sh = SIGNATURE;
                    end
                end
                PH_DATA:
                begin
                    // protection frozen here; later pin moves are ignored
                    if (s_ff.cmd == `SEL_CMD_WRSR && nxt_s.cnt == `SEL_WRSR_END)
                    begin
                        nxt_s.st_data = nxt_s.sh;
                        nxt_s.st_prot = !s_ff.wp_s2 && i_pin_enable;
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (go && fall && s_ff.phase == PH_SIG)
        begin
            nxt_s.so = s_ff.sig_sh[7];
            nxt_s.sig_sh = {s_ff.sig_sh[6:0], s_ff.sig_sh[7]};
        end

        // released when deselected, paused or hold low
        nxt_s.so_oe_n = !(!s_ff.cs_s2 && s_ff.hold_s2 && !nxt_s.paused
                          && s_ff.phase == PH_SIG);
        nxt_s.standby = s_ff.cs_s2 && !i_wip && s_ff.rel_cnt == '0 && !s_ff.dpd;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            s_ff <= RST;
        else
            s_ff <= nxt_s;
    end

    assign lnk.so = s_ff.so;
    assign lnk.so_oe_n = s_ff.so_oe_n;
    assign o_dpd = s_ff.dpd;
    assign o_standby = s_ff.standby;
    assign o_wr_start = s_ff.wr_start;
    assign o_status_wr = s_ff.st_wr;
    assign o_status_refused = s_ff.st_ref;
    assign o_status_data = s_ff.st_data;

endmodule

// ### sel_cfg.svh
/*
 constants of the serial eeprom link: opcodes, bit counts, timing.
 assumes a 10 MHz system clock on both ends.
*/
`ifndef SEL_CFG_SVH
`define SEL_CFG_SVH

`define SEL_CMD_SIG     8'hab
`define SEL_CMD_DPD     8'hb9
`define SEL_CMD_WREN    8'h06
`define SEL_CMD_WRSR    8'h01
`define SEL_CMD_WRITE   8'h02
`define SEL_SIG_DEFAULT 8'h5a

`define SEL_CMD_BITS    6'd8
`define SEL_WRSR_END    6'd16
`define SEL_ADDR_END    6'd32
`define SEL_DATA_WRAP   6'd33
`define SEL_DATA_END    6'd40
`define SEL_CNT_MAX     6'd63
`define SEL_BYTE_BITS   4'd8
`define SEL_BUF_FULL    2'd2

`define SEL_CLK_MHZ     10
`define SEL_REL_NS      3000
`define SEL_REL_CYC     8'((`SEL_REL_NS * `SEL_CLK_MHZ + 999) / 1000)

`define SEL_DIV_LAST    5'd7

`endif

// ### sel_pkg.sv
/*
 types shared by both ends of the serial eeprom link.
 assumes sel_cfg.svh is on the include path.
*/
package sel_pkg;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CMD  = 3'b001,
        PH_ADDR = 3'b010,
        PH_SIG  = 3'b011,
        PH_DATA = 3'b100,
        PH_SKIP = 3'b101
    } sel_ph_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_ARM  = 3'b001,
        H_TX   = 3'b010,
        H_RX   = 3'b011,
        H_END  = 3'b100,
        H_GAP  = 3'b101
    } sel_hph_t;

    typedef struct packed {
        logic       cs_s1;
        logic       cs_s2;
        logic       cs_d;
        logic       sck_s1;
        logic       sck_s2;
        logic       sck_d;
        logic       si_s1;
        logic       si_s2;
        logic       hold_s1;
        logic       hold_s2;
        logic       wp_s1;
        logic       wp_s2;
        sel_ph_t    phase;
        logic       paused;
        logic       armed;
        logic [5:0] cnt;
        logic [7:0] sh;
        logic [7:0] cmd;
        logic [7:0] sig_sh;
        logic       so;
        logic       so_oe_n;
        logic       dpd;
        logic [7:0] rel_cnt;
        logic       wel;
        logic       st_prot;
        logic       st_wr;
        logic       st_ref;
        logic [7:0] st_data;
        logic       wr_start;
        logic       standby;
    } sel_dev_st_t;

    typedef struct packed {
        sel_hph_t        phase;
        logic            cs_n;
        logic            sck;
        logic            si;
        logic            hold_n;
        logic            wp_n;
        logic            armed;
        logic [4:0]      div;
        logic [31:0]     tx;
        logic [5:0]      left;
        logic [3:0]      rd_left;
        logic [3:0]      bit8;
        logic [7:0]      rx;
        logic            so_s1;
        logic            so_s2;
        logic [1:0][7:0] bufm;
        logic            wp;
        logic            rp;
        logic [1:0]      bcnt;
        logic            rvalid;
        logic [7:0]      rdata;
        logic            ready;
    } sel_host_st_t;

endpackage

// ### sel_link_if.sv
/*
 the four-wire link plus hold and write-protect pins.
 assumes a pull-up on the shared serial output wire.
*/
`timescale 1ns/1ps
interface sel_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic so;
    logic so_oe_n;
    logic so_line;

    // released wire floats high through the pull-up
    assign so_line = so_oe_n ? 1'b1 : so;

    modport dev (input cs_n, input sck, input si, input hold_n, input wp_n, output so, output so_oe_n);
    modport host (output cs_n, output sck, output si, output hold_n, output wp_n, input so_line);
endinterface

// ### sel_host.sv
/*
 host end: bus master that shifts a 32-bit command word, zero-padded to up to 63 bits, reads bytes
 back into a two-entry buffer, and handles pause and write-protect pins.
 assumes the device end samples with the same system clock rate.
*/
`timescale 1ns/1ps
`include "sel_cfg.svh"
module sel_host
    import sel_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // link
    sel_link_if.host         lnk,
    // command request
    input  wire logic        i_op_valid,
    input  wire logic [31:0] i_op_tx,
    input  wire logic [5:0]  i_op_bits,
    input  wire logic [3:0]  i_op_rd,
    output logic             o_op_ready,
    // pins steered by user
    input  wire logic        i_pause,
    input  wire logic        i_wp_n,
    // read data
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data,
    input  wire logic        i_rd_ready
);

    localparam sel_host_st_t RST = '{
        phase: H_IDLE, cs_n: 1'b1, hold_n: 1'b1, wp_n: 1'b1,
        so_s1: 1'b1, so_s2: 1'b1, default: '0};

    sel_host_st_t s_ff;
    sel_host_st_t nxt_s;
    logic         tick;
    logic         pop;
    logic         push;

    always_comb
    begin
        nxt_s = s_ff;
        push = 1'b0;
        tick = s_ff.div == `SEL_DIV_LAST;
        pop = i_rd_ready && s_ff.rvalid;
        nxt_s.div = tick ? '0 : 5'(s_ff.div + 5'd1);
        nxt_s.so_s1 = lnk.so_line;
        nxt_s.so_s2 = s_ff.so_s1;
        nxt_s.wp_n = i_wp_n;
        case (s_ff.phase)
            H_IDLE:
            begin
                if (!s_ff.armed)
                begin
                    nxt_s.phase = H_ARM;
                    nxt_s.cs_n = 1'b0;
                    nxt_s.div = '0;
                end
                else if (i_op_valid && s_ff.ready)
                begin
                    nxt_s.phase = H_TX;
                    nxt_s.cs_n = 1'b0;
                    nxt_s.tx = i_op_tx;
                    nxt_s.si = i_op_tx[31];
                    nxt_s.left = i_op_bits;
                    nxt_s.rd_left = i_op_rd;
                    nxt_s.div = '0;
                end
            end
            H_ARM, H_END:
            begin
                if (tick)
                begin
                    nxt_s.cs_n = 1'b1;
                    nxt_s.armed = 1'b1;
                    nxt_s.phase = H_GAP;
                end
            end
            H_GAP:
            begin
                if (tick)
                    nxt_s.phase = H_IDLE;
            end
            H_TX, H_RX:
            begin
                if (tick && !s_ff.sck)
                begin
                    // pause moves only while the clock is low
                    if (i_pause)
                        nxt_s.hold_n = 1'b0;
                    else if (!s_ff.hold_n)
                        nxt_s.hold_n = 1'b1;
                    else if (s_ff.phase == H_TX)
                    begin
                        nxt_s.sck = 1'b1;
                        nxt_s.left = 6'(s_ff.left - 6'd1);
                    end
                    else if (s_ff.bit8 != '0 || s_ff.bcnt != `SEL_BUF_FULL)
                    begin
                        // a full buffer parks the clock low before a byte
                        nxt_s.sck = 1'b1;
                        nxt_s.rx = {s_ff.rx[6:0], s_ff.so_s2};
                        nxt_s.bit8 = 4'(s_ff.bit8 + 4'd1);
                        push = s_ff.bit8 == 4'(`SEL_BYTE_BITS - 4'd1);
                    end
                end
                else if (tick)
                begin
                    nxt_s.sck = 1'b0;
                    if (s_ff.phase == H_TX && s_ff.left == '0)
                    begin
                        nxt_s.phase = (s_ff.rd_left != '0) ? H_RX : H_END;
                        nxt_s.bit8 = '0;
                    end
                    else if (s_ff.phase == H_TX)
                    begin
                        nxt_s.tx = {s_ff.tx[30:0], 1'b0};
                        nxt_s.si = s_ff.tx[30];
                    end
                    else if (s_ff.bit8 == `SEL_BYTE_BITS)
                    begin
                        nxt_s.bit8 = '0;
                        nxt_s.rd_left = 4'(s_ff.rd_left - 4'd1);
                        if (s_ff.rd_left == 4'd1)
                            nxt_s.phase = H_END;
                    end
                end
            end
            default:
                nxt_s.phase = H_IDLE;
        endcase

        if (push)
        begin
            nxt_s.bufm[s_ff.wp] = {s_ff.rx[6:0], s_ff.so_s2};
            nxt_s.wp = !s_ff.wp;
        end
        if (pop)
            nxt_s.rp = !s_ff.rp;
        nxt_s.bcnt = 2'(s_ff.bcnt + {1'b0, push} - {1'b0, pop});
        nxt_s.rvalid = nxt_s.bcnt != '0;
        nxt_s.rdata = nxt_s.bufm[nxt_s.rp];
        nxt_s.ready = nxt_s.phase == H_IDLE && nxt_s.armed;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            s_ff <= RST;
        else
            s_ff <= nxt_s;
    end

    assign lnk.cs_n = s_ff.cs_n;
    assign lnk.sck = s_ff.sck;
    assign lnk.si = s_ff.si;
    assign lnk.hold_n = s_ff.hold_n;
    assign lnk.wp_n = s_ff.wp_n;
    assign o_op_ready = s_ff.ready;
    assign o_rd_valid = s_ff.rvalid;
    assign o_rd_data = s_ff.rdata;

endmodule

// ### sel_link_props.sv
/*
 checker of the shared link wires between host and device ends.
 assumes instantiation beside the link interface, on the system clock.
*/
`timescale 1ns/1ps
module sel_link_props
(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // link wires
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic so,
    input  wire logic so_oe_n
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    a_desel_release: assert property ($rose(cs_n) |-> ##[1:5] so_oe_n)
        else $error("output still driven after deselect");
    a_desel_quiet: assert property (cs_n [*6] |-> so_oe_n)
        else $error("output driven while deselected");
    a_pause_release: assert property ($fell(hold_n) |-> ##[1:5] so_oe_n)
        else $error("output still driven during pause");
    // device delay after the fall is far below the half period
    a_so_after_fall: assert property (!so_oe_n && !$past(so_oe_n) && !$stable(so) |-> !sck)
        else $error("output changed while clock high");
    a_si_steady: assert property (sck && $past(sck) |-> $stable(si))
        else $error("input changed while clock high");
    a_sck_high_len: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
        else $error("clock high phase not eight cycles");
    a_hold_sck_low: assert property (!hold_n |-> !sck)
        else $error("clock high while paused");
    a_hold_selected: assert property (!hold_n |-> !cs_n)
        else $error("deselected during pause");
    a_hold_idle: assert property (cs_n |-> hold_n)
        else $error("pause low while idle");
    a_cs_sck_idle: assert property (cs_n |-> !sck)
        else $error("clock high while deselected");

    c_sig_out: cover property ($fell(so_oe_n));
    c_pause: cover property ($fell(hold_n));
    c_frame_end: cover property ($rose(cs_n));
endmodule

// ### tb_top.sv
/*
 testbench: host end and device end joined by the link interface.
 assumes the design files and sel_cfg.svh are on the include path.
*/
`timescale 1ns/1ps
`include "sel_cfg.svh"
module tb_top;
    import sel_pkg::*;
    // arbitrary value, asymmetric so bit order shows
    localparam logic [7:0] SIG = 8'h1d;
    // per case: enable, pin, wren, accepted, refused
    localparam logic [4:0] CASES [4] = '{5'b00110, 5'b10101, 5'b11110, 5'b01000};
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        op_valid = 1'b0;
    logic [31:0] op_tx = 32'h0;
    logic [5:0]  op_bits = 6'h1;
    logic [3:0]  op_rd = 4'h0;
    logic        op_ready;
    logic        pause = 1'b0;
    logic        wp_n = 1'b1;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        rd_ready = 1'b1;
    logic        pin_enable = 1'b0;
    logic        wip = 1'b0;
    logic        dpd;
    logic        standby;
    logic        st_wr;
    logic        st_ref;
    logic [7:0]  st_data;
    logic        wr_start;
    logic [7:0]  rx_q [$];
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          n_wr = 0;
    int          n_ref = 0;
    int          n_start = 0;
    int          w0;
    int          r0;
    int          s0;

    sel_link_if lnk();
    sel_dev #(.SIGNATURE(SIG)) i_sel_dev (.i_sys_clk(sys_clk), .i_rst(rst), .lnk(lnk), .i_pin_enable(pin_enable),
        .i_wip(wip), .o_dpd(dpd), .o_standby(standby), .o_wr_start(wr_start), .o_status_wr(st_wr),
        .o_status_refused(st_ref), .o_status_data(st_data));
    sel_host i_sel_host (.i_sys_clk(sys_clk), .i_rst(rst), .lnk(lnk), .i_op_valid(op_valid), .i_op_tx(op_tx),
        .i_op_bits(op_bits), .i_op_rd(op_rd), .o_op_ready(op_ready), .i_pause(pause), .i_wp_n(wp_n),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_rd_ready(rd_ready));
    sel_link_props i_sel_link_props (.i_sys_clk(sys_clk), .i_rst(rst), .cs_n(lnk.cs_n), .sck(lnk.sck),
        .si(lnk.si), .hold_n(lnk.hold_n), .so(lnk.so), .so_oe_n(lnk.so_oe_n));

    always #50 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // pops and pulses counted on the sampled values of each edge
    always @(posedge sys_clk)
    begin
        cycles++;
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
            rx_q.push_back(rd_data);
        if (st_wr === 1'b1)
            n_wr++;
        if (st_ref === 1'b1)
            n_ref++;
        if (wr_start === 1'b1)
            n_start++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic send(input logic [31:0] tx, input logic [5:0] bits, input logic [3:0] rd);
        while (op_ready !== 1'b1)
            @(negedge sys_clk);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_tx <= tx;
        op_bits <= bits;
        op_rd <= rd;
        @(posedge sys_clk);
        op_valid <= 1'b0;
    endtask

    task automatic op(input logic [31:0] tx, input logic [5:0] bits, input logic [3:0] rd);
        send(tx, bits, rd);
        @(negedge sys_clk);
        while (op_ready !== 1'b1)
            @(negedge sys_clk);
    endtask

    task automatic expect_bytes(input int n, input logic [7:0] v);
        check("byte count", 8'(rx_q.size()), 8'(n));
        while (rx_q.size() > 0)
            check("read byte", rx_q.pop_front(), v);
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        op({`SEL_CMD_SIG, 24'h0}, 6'd32, 4'd1);
        expect_bytes(1, SIG);
        check("standby", 8'(standby), 8'h1);
        check("released", 8'(lnk.so_oe_n), 8'h1);
        // receiver stalls: two bytes parked, clock held, none lost
        @(posedge sys_clk);
        rd_ready <= 1'b0;
        send({`SEL_CMD_SIG, 24'h0}, 6'd32, 4'd4);
        repeat (1100) @(negedge sys_clk);
        check("parked ready", 8'(op_ready), 8'h0);
        check("parked valid", 8'(rd_valid), 8'h1);
        @(posedge sys_clk);
        rd_ready <= 1'b1;
        op(32'h0, 6'd1, 4'd0);
        expect_bytes(4, SIG);
        // busy device: wire stays at pull-up level
        @(posedge sys_clk);
        wip <= 1'b1;
        op({`SEL_CMD_SIG, 24'h0}, 6'd32, 4'd1);
        expect_bytes(1, 8'hff);
        check("standby busy", 8'(standby), 8'h0);
        @(posedge sys_clk);
        wip <= 1'b0;
        repeat (4) @(negedge sys_clk);
        check("standby done", 8'(standby), 8'h1);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            pin_enable <= CASES[i][4];
            wp_n <= CASES[i][3];
            if (CASES[i][2])
                op({`SEL_CMD_WREN, 24'h0}, 6'd8, 4'd0);
            w0 = n_wr;
            r0 = n_ref;
            s0 = n_start;
            op({`SEL_CMD_WRSR, 8'(8'h3c + i), 16'h0}, 6'd16, 4'd0);
            check("accepted", 8'(n_wr - w0), {7'h0, CASES[i][1]});
            check("refused", 8'(n_ref - r0), {7'h0, CASES[i][0]});
            check("cycle start", 8'(n_start - s0), {7'h0, CASES[i][1]});
            if (CASES[i][1])
                check("status data", st_data, 8'(8'h3c + i));
        end
        // pin drops once the write has been launched
        @(posedge sys_clk);
        pin_enable <= 1'b1;
        wp_n <= 1'b1;
        op({`SEL_CMD_WREN, 24'h0}, 6'd8, 4'd0);
        w0 = n_wr;
        send({`SEL_CMD_WRSR, 8'ha5, 16'h0}, 6'd16, 4'd0);
        while (lnk.cs_n !== 1'b0)
            @(negedge sys_clk);
        while (lnk.cs_n !== 1'b1)
            @(negedge sys_clk);
        @(posedge sys_clk);
        wp_n <= 1'b0;
        op(32'h0, 6'd1, 4'd0);
        check("late pin", 8'(n_wr - w0), 8'h1);
        // data write with the pin low: only whole bytes start a cycle
        s0 = n_start;
        op({`SEL_CMD_WREN, 24'h0}, 6'd8, 4'd0);
        op({`SEL_CMD_WRITE, 24'h0}, 6'd39, 4'd0);
        check("write short", 8'(n_start - s0), 8'h0);
        op({`SEL_CMD_WRITE, 24'h0}, 6'd40, 4'd0);
        check("write start", 8'(n_start - s0), 8'h1);
        @(posedge sys_clk);
        wp_n <= 1'b1;
        pin_enable <= 1'b0;
        op({`SEL_CMD_DPD, 24'h0}, 6'd9, 4'd0);
        check("dpd extra bit", 8'(dpd), 8'h0);
        op({`SEL_CMD_DPD, 24'h0}, 6'd8, 4'd0);
        check("dpd entered", 8'(dpd), 8'h1);
        w0 = n_wr;
        op({`SEL_CMD_WREN, 24'h0}, 6'd8, 4'd0);
        op({`SEL_CMD_WRSR, 8'h77, 16'h0}, 6'd16, 4'd0);
        check("dpd ignores", 8'(n_wr - w0), 8'h0);
        op({`SEL_CMD_SIG, 24'h0}, 6'd8, 4'd0);
        repeat (30) @(negedge sys_clk);
        check("dpd released", 8'(dpd), 8'h0);
        check("standby wake", 8'(standby), 8'h1);
        // pause inside the signature byte
        send({`SEL_CMD_SIG, 24'h0}, 6'd32, 4'd1);
        repeat (600) @(negedge sys_clk);
        @(posedge sys_clk);
        pause <= 1'b1;
        repeat (40) @(negedge sys_clk);
        check("paused", 8'(lnk.hold_n), 8'h0);
        check("pause release", 8'(lnk.so_oe_n), 8'h1);
        check("pause select", 8'(lnk.cs_n), 8'h0);
        @(posedge sys_clk);
        pause <= 1'b0;
        op(32'h0, 6'd1, 4'd0);
        expect_bytes(1, SIG);
        give_verdict();
    end
endmodule
